// ==== hdl/svp_scaled_port.v ====
// Output port controller of the video scaler: APB registers, field logic, burst and transparent transfer
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "svp_port_map.vh"
module svp_scaled_port (
	// Clock (the pixel clock) and reset
	input wire clk_sys,
	input wire reset_n,
	// APB slave
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Scaled word stream from the datapath
	input wire wordValid,
	input wire [31:0] wordData,
	// Video timing pins
	input wire horizReferenceIn,
	input wire verticalSyncIn,
	// Memory controller port
	input wire outputDrainClock,
	input wire outputEnableN,
	output reg [31:0] outputDataBus,
	output wire outputDataOe,
	output reg halfFullRequest,
	output reg addrIncrementStrobe
);
	localparam S_IDLE = 3'd0;
	localparam S_WAITVS = 3'd1;
	localparam S_SEQ = 3'd2;
	localparam S_LINE = 3'd3;
	localparam S_PAD = 3'd4;
	localparam S_WAITH = 3'd5;

	reg hrefS1, hrefS2, hrefS3;
	reg vsS1, vsS2, vsS3;
	reg vclkS1, vclkS2, vclkS3;
	reg oenS1, oenS2;
	reg [6:0] fmtQ;
	reg [3:0] ctlLiveQ;
	reg poeLiveQ;
	reg [9:0] xoLiveQ, xsLiveQ, yoLiveQ, ysLiveQ;
	reg [1:0] ofQ;
	reg [3:0] ctlQ;
	reg poeQ;
	reg [9:0] xoQ, xsQ, yoQ, ysQ;
	reg [10:0] pixCnt;
	reg [10:0] lineCnt;
	reg hGateQ;
	reg hrefDlyQ;
	reg fieldStatusQ;
	reg fieldFlagQ;
	reg [2:0] stateQ;
	reg [3:0] seqCnt;
	reg [1:0] seqLeft;
	reg seqLevel;
	reg lineSeen;
	reg flushQ;
	wire hrefRise, hrefFall, vsFall, vclkRise;
	wire apbWrite;
	wire port_outputs_enable, ttrMode, oddField, ignoreField;
	wire vGate, hGate, lnqRaw, pxqRaw;
	wire lineEnd;
	wire [31:0] headData;
	wire [4:0] level;
	wire push;
	wire [31:0] pushData;
	wire pop;
	wire [1:0] seqPerLine;

	// Two-stage synchronisers; stage three only feeds edge detection
	always @(posedge clk_sys)
	begin
		hrefS1 <= horizReferenceIn;
		hrefS2 <= hrefS1;
		hrefS3 <= hrefS2;
		vsS1 <= verticalSyncIn;
		vsS2 <= vsS1;
		vsS3 <= vsS2;
		vclkS1 <= outputDrainClock;
		vclkS2 <= vclkS1;
		vclkS3 <= vclkS2;
		oenS1 <= outputEnableN;
		oenS2 <= oenS1;
	end

	assign hrefRise = hrefS2 && !hrefS3;
	assign hrefFall = !hrefS2 && hrefS3;
	assign vsFall = !vsS2 && vsS3;
	assign vclkRise = vclkS2 && !vclkS3;

	// APB: zero wait states, unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr > `SVP_ADDR_STATUS || paddr[1:0] != 2'b00);
	assign apbWrite = psel && penable && pwrite && !pslverr;

	// Software-visible register copies
	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			fmtQ <= 7'h00;
			ctlLiveQ <= `SVP_CONTROL_RST;
			poeLiveQ <= 1'b0;
			xoLiveQ <= 10'h000;
			xsLiveQ <= 10'h000;
			yoLiveQ <= 10'h000;
			ysLiveQ <= 10'h000;
		end
		else if (apbWrite)
		begin
			case (paddr)
				`SVP_ADDR_FORMAT: fmtQ <= pwdata[6:0];
				`SVP_ADDR_CONTROL: ctlLiveQ <= pwdata[3:0];
				`SVP_ADDR_FIELDPOL: poeLiveQ <= pwdata[0];
				`SVP_ADDR_HOFFSET: xoLiveQ <= pwdata[9:0];
				`SVP_ADDR_HCOUNT: xsLiveQ <= pwdata[9:0];
				`SVP_ADDR_VOFFSET: yoLiveQ <= pwdata[9:0];
				`SVP_ADDR_VCOUNT: ysLiveQ <= pwdata[9:0];
				default: fmtQ <= fmtQ;
			endcase
		end
	end

	// Working copies move over only at the sync fall so a field never sees a half-written setup
	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			ofQ <= 2'b00;
			ctlQ <= `SVP_CONTROL_RST;
			poeQ <= 1'b0;
			xoQ <= 10'h000;
			xsQ <= 10'h000;
			yoQ <= 10'h000;
			ysQ <= 10'h000;
		end
		else if (vsFall)
		begin
			ofQ <= fmtQ[`SVP_FMT_OFHI:`SVP_FMT_OFLO];
			ctlQ <= ctlLiveQ;
			poeQ <= poeLiveQ;
			xoQ <= xoLiveQ;
			xsQ <= xsLiveQ;
			yoQ <= yoLiveQ;
			ysQ <= ysLiveQ;
		end
	end

	// Status read mux
	always @*
	begin
		case (paddr)
			`SVP_ADDR_FORMAT: prdata = {25'h0, fmtQ};
			`SVP_ADDR_CONTROL: prdata = {28'h0, ctlLiveQ};
			`SVP_ADDR_FIELDPOL: prdata = {31'h0, poeLiveQ};
			`SVP_ADDR_HOFFSET: prdata = {22'h0, xoLiveQ};
			`SVP_ADDR_HCOUNT: prdata = {22'h0, xsLiveQ};
			`SVP_ADDR_VOFFSET: prdata = {22'h0, yoLiveQ};
			`SVP_ADDR_VCOUNT: prdata = {22'h0, ysLiveQ};
			`SVP_ADDR_STATUS: prdata = {19'h0, level, stateQ, 3'b000, fieldStatusQ, port_outputs_enable};
			default: prdata = 32'h00000000;
		endcase
	end

	// The port enable acts at once so a disabled port goes quiet without waiting for a field
	assign port_outputs_enable = fmtQ[`SVP_FMT_VPE];
	assign ttrMode = ctlQ[`SVP_CTL_TTR] && ctlQ[`SVP_CTL_EFE];
	assign oddField = fieldFlagQ ^ poeQ;
	assign ignoreField = ofQ[1] && (oddField == ofQ[0]);

	// Pixel counter per line and line counter per field
	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			pixCnt <= 11'h000;
			lineCnt <= 11'h000;
			hGateQ <= 1'b0;
			hrefDlyQ <= 1'b0;
		end
		else
		begin
			hGateQ <= hGate;
			hrefDlyQ <= hrefS2;
			if (hrefRise)
				pixCnt <= 11'h000;
			else if (hrefS2 && pixCnt != 11'h7FF)
				pixCnt <= pixCnt + 11'h001;
			if (vsFall)
				lineCnt <= 11'h000;
			else if (hrefFall && lineCnt != 11'h7FF)
				lineCnt <= lineCnt + 11'h001;
		end
	end

	// Window gates, truncated by the sync signals
	assign vGate = !vsS2 && (lineCnt >= {1'b0, yoQ}) && (lineCnt < ({1'b0, yoQ} + {1'b0, ysQ}));
	assign hGate = hrefS2 && (pixCnt >= {1'b0, xoQ}) && (pixCnt < ({1'b0, xoQ} + {1'b0, xsQ}));
	assign lnqRaw = vGate && hrefS2;
	assign pxqRaw = vGate && hGate && wordValid && !ignoreField;
	// Pixel count reached or reference dropped both close the gate
	assign lineEnd = hGateQ && !hGate;

	// Field phase: reference high at the sync fall marks an odd field
	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			fieldStatusQ <= 1'b0;
			fieldFlagQ <= 1'b0;
		end
		else if (vsFall)
		begin
			fieldStatusQ <= hrefS2;
			if (hrefS2 == fieldStatusQ)
				fieldFlagQ <= !fieldFlagQ;
			else
				fieldFlagQ <= hrefS2;
		end
	end

	// Buffer fill: scaled words while a line runs, fill words while padding
	assign push = !ttrMode && ((stateQ == S_LINE && pxqRaw) ||
		(stateQ == S_PAD && level != 5'h00 && level < `SVP_HALF));
	assign pushData = (stateQ == S_PAD) ? `SVP_FILL_WORD : wordData;
	assign pop = vclkRise && !ttrMode;
	assign seqPerLine = (ofQ == 2'b00) ? 2'd2 : 2'd1;

	svp_out_buffer u_buffer (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.flush(flushQ),
		.push(push),
		.pushData(pushData),
		.pop(pop),
		.headData(headData),
		.level(level)
	);

	// Operation cycle: idle, vertical reset, line loading, padding and increment sequences
	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			stateQ <= S_IDLE;
			seqCnt <= 4'h0;
			seqLeft <= 2'd0;
			seqLevel <= 1'b0;
			lineSeen <= 1'b0;
			flushQ <= 1'b1;
		end
		else if (!port_outputs_enable || ttrMode)
		begin
			stateQ <= S_IDLE;
			flushQ <= 1'b1;
		end
		else
		begin
			flushQ <= 1'b0;
			case (stateQ)
				S_IDLE:
					stateQ <= S_WAITVS;
				S_WAITVS:
				begin
					if (vsFall)
					begin
						stateQ <= S_SEQ;
						seqCnt <= 4'h0;
						seqLeft <= 2'd1;
						seqLevel <= 1'b0;
					end
				end
				S_SEQ:
				begin
					// Level stands from count 0; strobe rises at the setup count, then holds
					if (seqCnt == `SVP_HFL_SETUP + `SVP_HFL_HOLD)
					begin
						seqCnt <= 4'h0;
						flushQ <= 1'b1;
						if (seqLeft > 2'd1)
							seqLeft <= seqLeft - 2'd1;
						else if (!seqLevel && ofQ == 2'b00 && oddField)
						begin
							seqLeft <= 2'd1;
							seqLevel <= 1'b1;
						end
						else
						begin
							stateQ <= S_LINE;
							lineSeen <= 1'b0;
						end
					end
					else
						seqCnt <= seqCnt + 4'h1;
				end
				S_LINE:
				begin
					if (hGate && vGate)
						lineSeen <= 1'b1;
					if (vsFall)
					begin
						stateQ <= S_SEQ;
						seqCnt <= 4'h0;
						seqLeft <= 2'd1;
						seqLevel <= 1'b0;
					end
					else if (lineEnd && lineSeen && !ignoreField)
						stateQ <= S_PAD;
				end
				S_PAD:
				begin
					if (level == 5'h00 || level >= `SVP_HALF)
						stateQ <= S_WAITH;
				end
				S_WAITH:
				begin
					// Increments wait for the next reference so the transfer can finish first
					if (vsFall)
					begin
						stateQ <= S_SEQ;
						seqCnt <= 4'h0;
						seqLeft <= 2'd1;
						seqLevel <= 1'b0;
					end
					else if (hrefRise)
					begin
						stateQ <= S_SEQ;
						seqCnt <= 4'h0;
						seqLeft <= seqPerLine;
						seqLevel <= 1'b1;
					end
				end
				default:
					stateQ <= S_IDLE;
			endcase
		end
	end

	// Request and strobe pins; strobe idles high, low only before its rising edge
	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			halfFullRequest <= 1'b0;
			addrIncrementStrobe <= 1'b1;
		end
		else if (!port_outputs_enable || ttrMode)
		begin
			halfFullRequest <= 1'b0;
			addrIncrementStrobe <= 1'b1;
		end
		else if (stateQ == S_SEQ)
		begin
			halfFullRequest <= seqLevel;
			addrIncrementStrobe <= (seqCnt >= `SVP_HFL_SETUP);
		end
		else
		begin
			halfFullRequest <= (level >= `SVP_HALF);
			addrIncrementStrobe <= 1'b1;
		end
	end

	// Drain edge loads the bus: buffer head in burst mode, live stream with tags in transparent mode
	always @(posedge clk_sys)
	begin
		if (!reset_n)
			outputDataBus <= 32'h00000000;
		else if (vclkRise)
		begin
			if (ttrMode)
				outputDataBus <= {wordData[31:7], oddField, vGate, hGate, 1'b0, hrefDlyQ,
					lnqRaw ~^ ctlQ[`SVP_CTL_QPL], pxqRaw ~^ ctlQ[`SVP_CTL_QPP]};
			else
				outputDataBus <= headData;
		end
	end

	// Bus floats while disabled or while the enable pin is high; pops still happen while the pin is high
	assign outputDataOe = port_outputs_enable && !oenS2;
endmodule

// ==== hdl/svp_port_map.vh ====
// Register map, field positions, reset values and timing counts of the scaled video output port
// How it works
// - Half-full request rises while the buffer holds eight words or more.
// - At line end, leftover words are padded with fill words up to half full.
// - Increment strobe rising with request high means line address increment.
// - Increment strobe rising with request low means field end, addresses reset.
// - Request level held four clocks before and two after each strobe rise.
// - Next buffer word is presented at each rising drain clock edge.
// - Enable high floats the bus, yet drain clock edges still pop words.
// - Transparent mode streams live words continuously, one per rising drain clock edge.
// - Gates and line qualifier appear every field; pixel qualifier only active ones.
// - Vertical and horizontal gates span offset to offset plus count, cut by sync.
// - Line and pixel qualifier polarities follow their own control bits.
// - Reset floats the bus, strobe high, request low, clears control and enable.
// - Field phase found at vertical sync fall, reported in the field status bit.
// - Stable detection gives a free-running field flag, invertible by a polarity bit.
// - Upper field-mode bit set ignores one parity: only the vertical reset is sent.
// - Field mode zero sends two sequences per line, one extra after odd resets.
// - Software-written control takes effect at the vertical sync falling edge.
// - After reset idle; enabled, waits sync, sends vertical reset, awaits lines.
// - Line ends at pixel count or sync; increments follow any padding.
// - Sequences wait for sync and empty the buffer once sent.
// - Output buffer holds sixteen words of 32 bits.
// - Field status reads 0 for even and 1 for odd field.
`ifndef SVP_PORT_MAP_VH
`define SVP_PORT_MAP_VH
`define SVP_ADDR_FORMAT 8'h00
`define SVP_ADDR_CONTROL 8'h04
`define SVP_ADDR_FIELDPOL 8'h08
`define SVP_ADDR_HOFFSET 8'h0C
`define SVP_ADDR_HCOUNT 8'h10
`define SVP_ADDR_VOFFSET 8'h14
`define SVP_ADDR_VCOUNT 8'h18
`define SVP_ADDR_STATUS 8'h1C
`define SVP_FMT_OFHI 6
`define SVP_FMT_OFLO 5
`define SVP_FMT_VPE 4
`define SVP_CTL_QPL 3
`define SVP_CTL_QPP 2
`define SVP_CTL_TTR 1
`define SVP_CTL_EFE 0
`define SVP_CONTROL_RST 4'h0
`define SVP_DEPTH 16
`define SVP_HALF 5'h08
`define SVP_FILL_WORD 32'h00000000
`define SVP_HFL_SETUP 4'h4
`define SVP_HFL_HOLD 4'h2
`endif

// ==== hdl/svp_out_buffer.v ====
// Sixteen-word output buffer held in flip-flops
`timescale 1ns/1ns
`include "svp_port_map.vh"
module svp_out_buffer (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Control
	input wire flush,
	input wire push,
	input wire [31:0] pushData,
	input wire pop,
	// State
	output wire [31:0] headData,
	output reg [4:0] level
);
	reg [31:0] mem [0:`SVP_DEPTH-1];
	reg [3:0] wrPtr;
	reg [3:0] rdPtr;
	wire doPush;
	wire doPop;

	// Writes into a full buffer are dropped; an ignored request needs no recovery
	assign doPush = push && (level != 5'h10);
	assign doPop = pop && (level != 5'h00);
	assign headData = mem[rdPtr];

	// Storage write
	always @(posedge clk_sys)
	begin
		if (doPush)
			mem[wrPtr] <= pushData;
	end

	// Pointers and fill level; flush wins over everything
	always @(posedge clk_sys)
	begin
		if (!reset_n || flush)
		begin
			wrPtr <= 4'h0;
			rdPtr <= 4'h0;
			level <= 5'h00;
		end
		else
		begin
			if (doPush)
				wrPtr <= wrPtr + 4'h1;
			if (doPop)
				rdPtr <= rdPtr + 4'h1;
			if (doPush && !doPop)
				level <= level + 5'h01;
			else if (doPop && !doPush)
				level <= level - 5'h01;
		end
	end
endmodule

// ==== verification/svp_port_monitor.sv ====
// Checker of the output port pins and APB answers of the scaled video port
`timescale 1ns/1ns
module svp_port_monitor (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// APB
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Memory controller port
	input wire outputDrainClock,
	input wire outputEnableN,
	input wire [31:0] outputDataBus,
	input wire outputDataOe,
	input wire halfFullRequest,
	input wire addrIncrementStrobe
);
	logic prevDrain_q;
	logic [3:0] sinceRise_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// Cycles since the drain pin was last sampled rising; saturates so idle gaps stay quiet
	always @(posedge clk_sys)
	begin
		prevDrain_q <= outputDrainClock;
		if (!reset_n)
			sinceRise_q <= 4'hF;
		else if (outputDrainClock && !prevDrain_q)
			sinceRise_q <= 4'h0;
		else if (sinceRise_q != 4'hF)
			sinceRise_q <= sinceRise_q + 4'h1;
	end
	property p_resetState;
		!$past(reset_n) |-> addrIncrementStrobe && !halfFullRequest && !outputDataOe;
	endproperty
	a_resetState: assert property (p_resetState) else $error("port not idle after reset");
	property p_hflSetup;
		$rose(addrIncrementStrobe) |-> $past(halfFullRequest, 1) == $past(halfFullRequest, 4)
			&& $past(halfFullRequest, 2) == $past(halfFullRequest, 4) && $past(halfFullRequest, 3) == $past(halfFullRequest, 4);
	endproperty
	a_hflSetup: assert property (p_hflSetup) else $error("request moved before strobe rise");
	property p_hflHold;
		$rose(addrIncrementStrobe) |-> $stable(halfFullRequest)[*3];
	endproperty
	a_hflHold: assert property (p_hflHold) else $error("request moved after strobe rise");
	property p_strobeWidth;
		$fell(addrIncrementStrobe) |-> !addrIncrementStrobe[*4] ##1 addrIncrementStrobe;
	endproperty
	a_strobeWidth: assert property (p_strobeWidth) else $error("strobe low time wrong");
	property p_floatBus;
		$past(outputEnableN, 2) && $past(outputEnableN, 3) |-> !outputDataOe;
	endproperty
	a_floatBus: assert property (p_floatBus) else $error("bus driven while disabled");
	property p_busCause;
		!$stable(outputDataBus) |-> sinceRise_q >= 4'h1 && sinceRise_q <= 4'h6;
	endproperty
	a_busCause: assert property (p_busCause) else $error("bus changed without drain edge");
	property p_zeroWait;
		psel && penable |-> pready;
	endproperty
	a_zeroWait: assert property (p_zeroWait) else $error("access not answered at once");
	property p_unmapped;
		psel && penable && (paddr > 8'h1C || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	c_lineInc: cover property ($rose(addrIncrementStrobe) && halfFullRequest);
	c_fieldReset: cover property ($rose(addrIncrementStrobe) && !halfFullRequest);
	c_floatPop: cover property (!outputDataOe && !$stable(outputDataBus));
endmodule
bind svp_scaled_port svp_port_monitor svp_port_monitor_inst (.clk_sys, .reset_n, .paddr, .psel, .penable,
	.prdata, .pready, .pslverr, .outputDrainClock, .outputEnableN, .outputDataBus, .outputDataOe,
	.halfFullRequest, .addrIncrementStrobe);

// ==== verification/svp_mem_ctrl_model.sv ====
// Memory controller model that drains the output buffer in bursts of eight words
`timescale 1ns/1ns
module svp_mem_ctrl_model (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Port pins
	input wire halfFullRequest,
	input wire addrIncrementStrobe,
	input wire [31:0] outputDataBus,
	input wire outputDataOe,
	output logic outputDrainClock,
	output logic outputEnableN,
	// Float the bus during the first pop of a burst
	input wire floatFirst
);
	logic [31:0] seenWords[$];
	int cnt;
	// Drain clock stands low between bursts; a request held 6 cycles outside a strobe starts one
	// Sequences hold the request with the strobe high for 3 cycles at most, so they never start a burst
	initial
	begin
		outputDrainClock = 1'b0;
		outputEnableN = 1'b1;
		cnt = 0;
		forever
		begin
			@(posedge clk_sys);
			cnt = (reset_n && halfFullRequest && addrIncrementStrobe) ? cnt + 1 : 0;
			if (cnt == 6) // First drain edge 14 pixel clocks after the request
			begin
				cnt = 0;
				for (int i = 0; i < 8; i++)
				begin
					// Enable moves one edge after the drain clock fell
					@(posedge clk_sys);
					outputEnableN <= floatFirst && i == 0;
					repeat (7) @(posedge clk_sys);
					outputDrainClock <= 1'b1;
					repeat (8) @(posedge clk_sys);
					if (outputDataOe)
						seenWords.push_back(outputDataBus);
					outputDrainClock <= 1'b0;
				end
				@(posedge clk_sys);
				outputEnableN <= 1'b1;
			end
		end
	end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench of the scaled video output port
`timescale 1ns/1ns
module tb_top;
	logic clk_sys, reset_n, psel, penable, pwrite, wordValid, horizReferenceIn, verticalSyncIn, floatFirst;
	logic pready, pslverr, outputDrainClock, outputEnableN, outputDataOe, halfFullRequest, addrIncrementStrobe;
	logic errSeen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, wordData, outputDataBus, rd;
	logic [31:0] regVal[1:6] = '{32'hC, 32'h0, 32'h0, 32'h190, 32'h0, 32'hA};
	int errTotal, totalChecks, lineIncs, fieldIncs;
	svp_scaled_port svp_scaled_port_inst (.clk_sys, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .wordValid, .wordData, .horizReferenceIn, .verticalSyncIn, .outputDrainClock,
		.outputEnableN, .outputDataBus, .outputDataOe, .halfFullRequest, .addrIncrementStrobe);
	svp_mem_ctrl_model svp_mem_ctrl_model_inst (.clk_sys, .reset_n, .halfFullRequest, .addrIncrementStrobe,
		.outputDataBus, .outputDataOe, .outputDrainClock, .outputEnableN, .floatFirst);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// One APB transfer, entered just after a rising edge; holds the request until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		do
		begin
			tick(1);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n == 50)
			errTotal++;
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask
	// Field start: vertical sync pulse with the reference at the given level on its fall
	task automatic field(input logic refLevel);
		horizReferenceIn <= refLevel;
		verticalSyncIn <= 1'b1;
		tick(10);
		verticalSyncIn <= 1'b0;
		tick(60);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Strobe rises sorted by request level
	always @(posedge addrIncrementStrobe)
		if (reset_n === 1'b1)
			if (halfFullRequest) lineIncs++; else fieldIncs++;
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#100000;
		errTotal++;
		summarize();
	end
	// Main sequence
	initial
	begin
		{reset_n, psel, penable, pwrite, wordValid, horizReferenceIn, verticalSyncIn, paddr, pwdata, wordData} = '0;
		floatFirst = 1'b1;
		tick(4);
		reset_n <= 1'b1;
		tick(1);
		check("strobe", addrIncrementStrobe, 1);
		check("request", halfFullRequest, 0);
		apb(0, 8'h1C, 0);
		check("status", rd, 0);
		apb(0, 8'h22, 0);
		check("slverr", errSeen, 1);
		for (int j = 1; j <= 6; j++) apb(1, 8'h04 * j, regVal[j]);
		for (int j = 1; j <= 6; j++)
		begin
			apb(0, 8'h04 * j, 0);
			check("readback", rd, regVal[j]);
		end
		apb(1, 8'h00, 32'h10);
		apb(0, 8'h1C, 0);
		check("enable", rd[0], 1);
		field(1'b0);
		check("fieldResets", fieldIncs, 1);
		// First unchanged detection after reset toggles the free-running flag, so this field runs as odd
		check("firstOddIncs", lineIncs, 1);
		apb(0, 8'h1C, 0);
		check("evenField", rd[1], 0);
		horizReferenceIn <= 1'b1;
		// Let the reference pass its synchroniser so all ten words land inside the gate
		tick(3);
		for (int i = 1; i <= 10; i++)
		begin
			wordValid <= 1'b1;
			wordData <= 32'hC0DE0000 + i;
			tick(1);
		end
		wordValid <= 1'b0;
		check("halfFull", halfFullRequest, 1);
		tick(300);
		floatFirst <= 1'b0;
		horizReferenceIn <= 1'b0;
		tick(250);
		horizReferenceIn <= 1'b1;
		tick(40);
		check("lineIncs", lineIncs, 3);
		check("drainCount", svp_mem_ctrl_model_inst.seenWords.size(), 15);
		for (int k = 0; k < 15; k++)
			check("drained", svp_mem_ctrl_model_inst.seenWords[k], k < 9 ? 32'hC0DE0002 + k : 32'h0);
		field(1'b1);
		check("oddIncs", lineIncs, 4);
		apb(0, 8'h1C, 0);
		check("oddField", rd[1], 1);
		apb(1, 8'h00, 32'h50);
		field(1'b0);
		horizReferenceIn <= 1'b1;
		tick(20);
		horizReferenceIn <= 1'b0;
		tick(20);
		horizReferenceIn <= 1'b1;
		tick(40);
		check("ignoredIncs", lineIncs, 4);
		check("ignoredResets", fieldIncs, 3);
		// Transparent mode: the port streams, so no request or strobe sequences follow
		apb(1, 8'h04, 32'hF);
		field(1'b1);
		check("ttrResets", fieldIncs, 3);
		check("ttrRequest", halfFullRequest, 0);
		summarize();
	end
endmodule
